// >>> rtl/asp3_top.sv
// Operation
// - set transmit-end after stop with holding empty
// - clear transmit-end when holding moves to shifter
// - transmit-empty read-only, set on move, cleared by write
// - one interrupt when any flag except receive-error and its enable are set
// - run bit stops or starts serial circuit
// - receive-error on parity, overrun or stop error
// - receive-ready set at stop, cleared by read
// - stop-length select picks one or two stops
// - receive checks first stop only, low starts next
// - mode 0 bit period from divider and prescale
// - clock-source field selects baud clock source
// - parity type even or odd in mode 0
// - parity enable inserts and checks parity, mode 0
// - wakeup flag set when enabled and pin low
// - divider zero selects mode 1
// - transmit start copies holding into shifter
// - receive end moves shifter into receive data
// - eight data bits, least significant first
// - mode 1 runs 9600 bps from crystal
// - keeps running and interrupting in processor halt
//
// Chosen here: register access over AXI4-Lite.
`include "asp3_regs.svh"

module asp3_top
    import asp3_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        ext_baud_pin,
    input  wire logic        first_oscillator,
    input  wire logic        second_oscillator,
    input  wire logic        rxd,
    output logic             txd,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers and baud source cycle detection

    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [2:0] src_last_reg;
    logic [3:0] sync1_next;
    logic [2:0] src_last_next;
    logic [2:0] src_rise;
    logic       cyc_tick;
    logic       rx_pin;

    logic [7:0] ctrl_reg;
    logic [7:0] fmt_reg;
    logic [7:0] txh_reg;
    logic [7:0] rxh_reg;
    logic [7:0] baud_reg;

    always_comb begin
        sync1_next    = {rxd, second_oscillator, first_oscillator, ext_baud_pin};
        src_last_next = sync2_reg[2:0];
        src_rise      = sync2_reg[2:0] & ~src_last_reg;
        rx_pin        = sync2_reg[3];
        case (fmt_reg[`ASP3_F_SCK_HI:`ASP3_F_SCK_LO])
            2'b00:   cyc_tick = 1'b1;
            2'b01:   cyc_tick = src_rise[0];
            2'b10:   cyc_tick = src_rise[1];
            default: cyc_tick = src_rise[2];
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg    <= 4'hf;
            sync2_reg    <= 4'hf;
            // matches the synchroniser preload so no false source edge follows reset
            src_last_reg <= 3'h7;
        end else begin
            sync1_reg    <= sync1_next;
            sync2_reg    <= sync1_reg;
            src_last_reg <= src_last_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bit timing: fractional accumulator serves both modes

    logic        mode1;
    logic [15:0] acc_step;
    logic [15:0] acc_limit;

    always_comb begin
        mode1 = (baud_reg == 8'h00);
        if (mode1) begin
            acc_step  = `ASP3_MODE1_BPS;
            acc_limit = `ASP3_XTAL_HZ;
        end else if (fmt_reg[`ASP3_F_DIV]) begin
            acc_step  = 16'h0001;
            acc_limit = {{4'h0, baud_reg} + 12'h001, 4'h0};
        end else begin
            acc_step  = 16'h0001;
            acc_limit = {{6'h00, baud_reg} + 14'h0001, 2'h0};
        end
    end

    // returns {bit tick, new accumulator}
    function automatic logic [16:0] acc_adv(input logic [15:0] acc,
                                            input logic        cyc,
                                            input logic [15:0] step,
                                            input logic [15:0] limit);
        logic [16:0] sum;
        sum = {1'b0, acc} + {1'b0, step};
        if (!cyc)
            acc_adv = {1'b0, acc};
        else if (sum >= {1'b0, limit})
            acc_adv = {1'b1, sum[15:0] - limit};
        else
            acc_adv = {1'b0, sum[15:0]};
    endfunction : acc_adv

    ////////////////////////////////////////////////////////////////////////
    // transmitter

    asp3_tx_state_e tx_state_reg;
    asp3_tx_state_e tx_state_next;
    logic [8:0]     tx_shifter_reg;
    logic [8:0]     tx_shifter_next;
    logic [15:0]    tx_acc_reg;
    logic [15:0]    tx_acc_next;
    logic [3:0]     tx_cnt_reg;
    logic [3:0]     tx_cnt_next;
    logic           txd_next;
    logic           tx_hit;
    logic           tx_load;
    logic           tx_done;
    logic           par_on;
    logic [16:0]    tx_adv;

    always_comb begin
        par_on          = !mode1 && fmt_reg[`ASP3_F_PEN];
        tx_adv          = acc_adv(tx_acc_reg, cyc_tick, acc_step, acc_limit);
        tx_hit          = tx_adv[16];
        tx_acc_next     = tx_adv[15:0];
        tx_state_next   = tx_state_reg;
        tx_shifter_next = tx_shifter_reg;
        tx_cnt_next     = tx_cnt_reg;
        tx_load         = 1'b0;
        tx_done         = 1'b0;
        case (tx_state_reg)
            ASP3_TX_IDLE: begin
                tx_acc_next = 16'h0000;
                if (!ctrl_reg[`ASP3_C_TRANSMIT_EMPTY_FLAG])
                    tx_load = 1'b1;
            end
            ASP3_TX_START: begin
                if (tx_hit) begin
                    tx_state_next = ASP3_TX_DATA;
                    tx_cnt_next   = 4'h0;
                end
            end
            ASP3_TX_DATA: begin
                if (tx_hit) begin
                    tx_shifter_next = {1'b1, tx_shifter_reg[8:1]};
                    tx_cnt_next     = tx_cnt_reg + 4'h1;
                    if (tx_cnt_reg == 4'h7) begin
                        tx_cnt_next   = 4'h0;
                        tx_state_next = par_on ? ASP3_TX_PAR : ASP3_TX_STOP;
                    end
                end
            end
            ASP3_TX_PAR: begin
                if (tx_hit)
                    tx_state_next = ASP3_TX_STOP;
            end
            ASP3_TX_STOP: begin
                if (tx_hit) begin
                    tx_cnt_next = tx_cnt_reg + 4'h1;
                    if (tx_cnt_reg[0] == fmt_reg[`ASP3_F_STOP_LENGTH_SELECT]) begin
                        if (!ctrl_reg[`ASP3_C_TRANSMIT_EMPTY_FLAG])
                            tx_load = 1'b1;
                        else begin
                            tx_done       = 1'b1;
                            tx_state_next = ASP3_TX_IDLE;
                        end
                    end
                end
            end
            default: tx_state_next = ASP3_TX_IDLE;
        endcase
        if (tx_load) begin
            // parity over the eight data bits, odd type inverts it
            tx_shifter_next = {(^txh_reg) ^ fmt_reg[`ASP3_F_PARITY_TYPE_SELECT], txh_reg};
            tx_state_next   = ASP3_TX_START;
            tx_acc_next     = 16'h0000;
        end
        if (!ctrl_reg[`ASP3_C_RUN]) begin
            tx_state_next = ASP3_TX_IDLE;
            tx_load       = 1'b0;
            tx_done       = 1'b0;
        end
        case (tx_state_next)
            ASP3_TX_START: txd_next = 1'b0;
            ASP3_TX_DATA:  txd_next = tx_shifter_next[0];
            ASP3_TX_PAR:   txd_next = tx_shifter_next[0];
            default:       txd_next = 1'b1;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_state_reg   <= ASP3_TX_IDLE;
            tx_shifter_reg <= 9'h1ff;
            tx_acc_reg     <= 16'h0000;
            tx_cnt_reg     <= 4'h0;
            txd            <= 1'b1;
        end else begin
            tx_state_reg   <= tx_state_next;
            tx_shifter_reg <= tx_shifter_next;
            tx_acc_reg     <= tx_acc_next;
            tx_cnt_reg     <= tx_cnt_next;
            txd            <= txd_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receiver: samples each bit at its middle

    asp3_rx_state_e rx_state_reg;
    asp3_rx_state_e rx_state_next;
    logic [7:0]     rx_shifter_reg;
    logic [7:0]     rx_shifter_next;
    logic [15:0]    rx_acc_reg;
    logic [15:0]    rx_acc_next;
    logic [2:0]     rx_cnt_reg;
    logic [2:0]     rx_cnt_next;
    logic           rx_perr_reg;
    logic           rx_perr_next;
    logic           rx_hit;
    logic           rx_done;
    logic           rx_err;
    logic [16:0]    rx_adv;

    always_comb begin
        rx_adv          = acc_adv(rx_acc_reg, cyc_tick, acc_step, acc_limit);
        rx_hit          = rx_adv[16];
        rx_acc_next     = rx_adv[15:0];
        rx_state_next   = rx_state_reg;
        rx_shifter_next = rx_shifter_reg;
        rx_cnt_next     = rx_cnt_reg;
        rx_perr_next    = rx_perr_reg;
        rx_done         = 1'b0;
        rx_err          = 1'b0;
        case (rx_state_reg)
            ASP3_RX_IDLE: begin
                // half-period preload lands samples mid-bit
                rx_acc_next = {1'b0, acc_limit[15:1]};
                if (!rx_pin) begin
                    rx_state_next = ASP3_RX_START;
                    rx_perr_next  = 1'b0;
                end
            end
            ASP3_RX_START: begin
                if (rx_hit) begin
                    rx_cnt_next   = 3'h0;
                    rx_state_next = rx_pin ? ASP3_RX_IDLE : ASP3_RX_DATA;  // glitch
                end
            end
            ASP3_RX_DATA: begin
                if (rx_hit) begin
                    rx_shifter_next = {rx_pin, rx_shifter_reg[7:1]};
                    rx_cnt_next     = rx_cnt_reg + 3'h1;
                    if (rx_cnt_reg == 3'h7)
                        rx_state_next = par_on ? ASP3_RX_PAR : ASP3_RX_STOP;
                end
            end
            ASP3_RX_PAR: begin
                if (rx_hit) begin
                    rx_perr_next  = rx_pin != ((^rx_shifter_reg) ^ fmt_reg[`ASP3_F_PARITY_TYPE_SELECT]);
                    rx_state_next = ASP3_RX_STOP;
                end
            end
            ASP3_RX_STOP: begin
                // only the first stop is checked; idle then hunts a new start
                if (rx_hit) begin
                    rx_done       = 1'b1;
                    rx_err        = rx_perr_reg || !rx_pin
                                    || ctrl_reg[`ASP3_C_RREADY];
                    rx_state_next = ASP3_RX_IDLE;
                end
            end
            default: rx_state_next = ASP3_RX_IDLE;
        endcase
        if (!ctrl_reg[`ASP3_C_RUN]) begin
            rx_state_next = ASP3_RX_IDLE;
            rx_done       = 1'b0;
            rx_err        = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_state_reg   <= ASP3_RX_IDLE;
            rx_shifter_reg <= 8'h00;
            rx_acc_reg     <= 16'h0000;
            rx_cnt_reg     <= 3'h0;
            rx_perr_reg    <= 1'b0;
        end else begin
            rx_state_reg   <= rx_state_next;
            rx_shifter_reg <= rx_shifter_next;
            rx_acc_reg     <= rx_acc_next;
            rx_cnt_reg     <= rx_cnt_next;
            rx_perr_reg    <= rx_perr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite slave and register file

    logic        aw_held_reg;
    logic        w_held_reg;
    logic [31:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic        wstrb0_reg;
    logic        aw_held_next;
    logic        w_held_next;
    logic [31:0] awaddr_next;
    logic [31:0] wdata_next;
    logic        wstrb0_next;
    logic        awready_next;
    logic        wready_next;
    logic        bvalid_next;
    logic [1:0]  bresp_next;
    logic        arready_next;
    logic        rvalid_next;
    logic [31:0] rdata_next;
    logic [1:0]  rresp_next;
    logic        do_wr;
    logic        wr_hit;
    logic        rd_take;
    logic [7:0]  rd_val;
    logic        rd_hit;
    logic        rd_rxh;
    logic [7:0]  wb;
    logic [7:0]  ctrl_next;
    logic [7:0]  fmt_next;
    logic [7:0]  txh_next;
    logic [7:0]  rxh_next;
    logic [7:0]  baud_next;
    logic        irq_next;

    function automatic logic at(input logic [31:0] a, input logic [15:0] idx);
        at = (a[31:2] == {14'h0000, idx}) && (a[1:0] == 2'b00);
    endfunction : at

    always_comb begin
        aw_held_next = aw_held_reg;
        w_held_next  = w_held_reg;
        awaddr_next  = awaddr_reg;
        wdata_next   = wdata_reg;
        wstrb0_next  = wstrb0_reg;
        bvalid_next  = s_axi_bvalid;
        bresp_next   = s_axi_bresp;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_next = 1'b1;
            awaddr_next  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_next = 1'b1;
            wdata_next  = s_axi_wdata;
            wstrb0_next = s_axi_wstrb[0];
        end
        do_wr  = aw_held_reg && w_held_reg && !s_axi_bvalid;
        wr_hit = at(awaddr_reg, `ASP3_IDX_CTRL) || at(awaddr_reg, `ASP3_IDX_FMT)
                 || at(awaddr_reg, `ASP3_IDX_TXH) || at(awaddr_reg, `ASP3_IDX_BAUD);
        if (do_wr) begin
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = wr_hit ? `ASP3_RESP_OKAY : `ASP3_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready)
            bvalid_next = 1'b0;
        awready_next = !aw_held_next && !bvalid_next;
        wready_next  = !w_held_next && !bvalid_next;

        rd_take = s_axi_arvalid && s_axi_arready;
        rd_hit  = 1'b1;
        rd_rxh  = 1'b0;
        if (at(s_axi_araddr, `ASP3_IDX_CTRL))
            rd_val = ctrl_reg;
        else if (at(s_axi_araddr, `ASP3_IDX_FMT))
            rd_val = fmt_reg;
        else if (at(s_axi_araddr, `ASP3_IDX_TXH))
            rd_val = txh_reg;
        else if (at(s_axi_araddr, `ASP3_IDX_RXH)) begin
            rd_val = rxh_reg;
            rd_rxh = rd_take;
        end else if (at(s_axi_araddr, `ASP3_IDX_BAUD))
            rd_val = baud_reg;
        else begin
            rd_val = 8'h00;
            rd_hit = 1'b0;
        end
        rvalid_next  = s_axi_rvalid;
        rdata_next   = s_axi_rdata;
        rresp_next   = s_axi_rresp;
        if (rd_take) begin
            rvalid_next = 1'b1;
            rdata_next  = {24'h00_0000, rd_val};
            rresp_next  = rd_hit ? `ASP3_RESP_OKAY : `ASP3_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready)
            rvalid_next = 1'b0;
        arready_next = !rvalid_next;

        // register file; hardware set wins over software clear
        wb        = wdata_reg[7:0];
        ctrl_next = ctrl_reg;
        fmt_next  = fmt_reg;
        txh_next  = txh_reg;
        rxh_next  = rxh_reg;
        baud_next = baud_reg;
        if (do_wr && wstrb0_reg) begin
            if (at(awaddr_reg, `ASP3_IDX_CTRL)) begin
                ctrl_next[`ASP3_C_TRANSMIT_END_IRQ_ENABLE]   = wb[`ASP3_C_TRANSMIT_END_IRQ_ENABLE];
                ctrl_next[`ASP3_C_TRANSMIT_EMPTY_IRQ_ENABLE] = wb[`ASP3_C_TRANSMIT_EMPTY_IRQ_ENABLE];
                ctrl_next[`ASP3_C_RUN]      = wb[`ASP3_C_RUN];
                ctrl_next[`ASP3_C_RIE]      = wb[`ASP3_C_RIE];
                ctrl_next[`ASP3_C_TRANSMIT_END_FLAG]     = ctrl_reg[`ASP3_C_TRANSMIT_END_FLAG] & wb[`ASP3_C_TRANSMIT_END_FLAG];
                ctrl_next[`ASP3_C_RECEIVE_ERROR_FLAG]     = ctrl_reg[`ASP3_C_RECEIVE_ERROR_FLAG] & wb[`ASP3_C_RECEIVE_ERROR_FLAG];
            end
            if (at(awaddr_reg, `ASP3_IDX_FMT))
                fmt_next = {wb[7:2], fmt_reg[`ASP3_F_WAKEUP_FLAG] & wb[`ASP3_F_WAKEUP_FLAG],
                            wb[`ASP3_F_WAKEUP_IRQ_ENABLE]};
            if (at(awaddr_reg, `ASP3_IDX_TXH)) begin
                txh_next                  = wb;
                ctrl_next[`ASP3_C_TRANSMIT_EMPTY_FLAG] = 1'b0;
            end
            if (at(awaddr_reg, `ASP3_IDX_BAUD))
                baud_next = wb;
        end
        if (rd_rxh)
            ctrl_next[`ASP3_C_RREADY] = 1'b0;
        if (tx_load) begin
            ctrl_next[`ASP3_C_TRANSMIT_EMPTY_FLAG] = 1'b1;
            ctrl_next[`ASP3_C_TRANSMIT_END_FLAG]   = 1'b0;
        end
        if (tx_done)
            ctrl_next[`ASP3_C_TRANSMIT_END_FLAG] = 1'b1;
        if (rx_done) begin
            rxh_next                  = rx_shifter_reg;
            ctrl_next[`ASP3_C_RREADY] = 1'b1;
        end
        if (rx_err)
            ctrl_next[`ASP3_C_RECEIVE_ERROR_FLAG] = 1'b1;
        if (fmt_reg[`ASP3_F_WAKEUP_IRQ_ENABLE] && !rx_pin)
            fmt_next[`ASP3_F_WAKEUP_FLAG] = 1'b1;
        // no halt input: nothing here ever pauses, so the request wakes the core
        irq_next = (ctrl_reg[`ASP3_C_TRANSMIT_END_FLAG] & ctrl_reg[`ASP3_C_TRANSMIT_END_IRQ_ENABLE])
                   | (ctrl_reg[`ASP3_C_TRANSMIT_EMPTY_FLAG] & ctrl_reg[`ASP3_C_TRANSMIT_EMPTY_IRQ_ENABLE])
                   | (ctrl_reg[`ASP3_C_RREADY] & ctrl_reg[`ASP3_C_RIE])
                   | (fmt_reg[`ASP3_F_WAKEUP_FLAG] & fmt_reg[`ASP3_F_WAKEUP_IRQ_ENABLE]);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            awaddr_reg    <= 32'h0000_0000;
            wdata_reg     <= 32'h0000_0000;
            wstrb0_reg    <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `ASP3_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `ASP3_RESP_OKAY;
            ctrl_reg      <= `ASP3_RST_CTRL;
            fmt_reg       <= `ASP3_RST_FMT;
            txh_reg       <= `ASP3_RST_TXH;
            rxh_reg       <= `ASP3_RST_RXH;
            baud_reg      <= `ASP3_RST_BAUD;
            irq           <= 1'b0;
        end else begin
            aw_held_reg   <= aw_held_next;
            w_held_reg    <= w_held_next;
            awaddr_reg    <= awaddr_next;
            wdata_reg     <= wdata_next;
            wstrb0_reg    <= wstrb0_next;
            s_axi_awready <= awready_next;
            s_axi_wready  <= wready_next;
            s_axi_bvalid  <= bvalid_next;
            s_axi_bresp   <= bresp_next;
            s_axi_arready <= arready_next;
            s_axi_rvalid  <= rvalid_next;
            s_axi_rdata   <= rdata_next;
            s_axi_rresp   <= rresp_next;
            ctrl_reg      <= ctrl_next;
            fmt_reg       <= fmt_next;
            txh_reg       <= txh_next;
            rxh_reg       <= rxh_next;
            baud_reg      <= baud_next;
            irq           <= irq_next;
        end
    end

endmodule : asp3_top

// >>> rtl/asp3_regs.svh
`ifndef ASP3_REGS_SVH
`define ASP3_REGS_SVH

// register indices; byte address is four times the index
`define ASP3_IDX_CTRL      16'h7f70
`define ASP3_IDX_FMT       16'h7f71
`define ASP3_IDX_TXH       16'h7f72
`define ASP3_IDX_RXH       16'h7f73
`define ASP3_IDX_BAUD      16'h7f75

`define ASP3_RST_CTRL      8'h20
`define ASP3_RST_FMT       8'h00
`define ASP3_RST_TXH       8'h00
`define ASP3_RST_RXH       8'h00
`define ASP3_RST_BAUD      8'h00

// serial_control_status fields
`define ASP3_C_TRANSMIT_END_FLAG        7
`define ASP3_C_TRANSMIT_END_IRQ_ENABLE      6
`define ASP3_C_TRANSMIT_EMPTY_FLAG      5
`define ASP3_C_TRANSMIT_EMPTY_IRQ_ENABLE    4
`define ASP3_C_RUN         3
`define ASP3_C_RECEIVE_ERROR_FLAG        2
`define ASP3_C_RREADY      1
`define ASP3_C_RIE         0

// frame_format_wakeup fields
`define ASP3_F_STOP_LENGTH_SELECT        7
`define ASP3_F_DIV         6
`define ASP3_F_SCK_HI      5
`define ASP3_F_SCK_LO      4
`define ASP3_F_PARITY_TYPE_SELECT        3
`define ASP3_F_PEN         2
`define ASP3_F_WAKEUP_FLAG      1
`define ASP3_F_WAKEUP_IRQ_ENABLE       0

// mode 1 rate: crystal hz and bit rate, as accumulator limit and step
`define ASP3_XTAL_HZ       16'h8000
`define ASP3_MODE1_BPS     16'h2580

`define ASP3_RESP_OKAY     2'b00
`define ASP3_RESP_SLVERR   2'b10

`endif

// >>> rtl/asp3_pkg.sv
package asp3_pkg;

    typedef enum logic [2:0] {
        ASP3_TX_IDLE,
        ASP3_TX_START,
        ASP3_TX_DATA,
        ASP3_TX_PAR,
        ASP3_TX_STOP
    } asp3_tx_state_e;

    typedef enum logic [2:0] {
        ASP3_RX_IDLE,
        ASP3_RX_START,
        ASP3_RX_DATA,
        ASP3_RX_PAR,
        ASP3_RX_STOP
    } asp3_rx_state_e;

endpackage : asp3_pkg

// >>> test/asp3_top_chk.sv
module asp3_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        txd
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bh: assert property (p_bh) else $error("bvalid dropped");
    property p_bd; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_bd: assert property (p_bd) else $error("bvalid stuck");
    property p_rh; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rh: assert property (p_rh) else $error("read answer moved");
    property p_rd; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("rvalid stuck");
    property p_ar; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_ar: assert property (p_ar) else $error("arready while busy");
    property p_aw; s_axi_bvalid |-> !s_axi_awready; endproperty
    a_aw: assert property (p_aw) else $error("awready while busy");
    property p_ud; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
    a_ud: assert property (p_ud) else $error("upper read bits set");
    // shortest bit period is over two clocks in every mode
    property p_tx; $fell(txd) |=> !txd [*2]; endproperty
    a_tx: assert property (p_tx) else $error("start bit short");
    c_wr: cover property (s_axi_bvalid && s_axi_bready);
    c_rd: cover property (s_axi_rvalid && s_axi_rready);
    c_tx: cover property ($fell(txd));
endmodule : asp3_chk
bind asp3_top asp3_chk asp3_chk_inst (.aclk, .aresetn, .s_axi_awready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .txd);

// >>> test/asp3_peer.sv
module asp3_peer #(parameter int P = 8) (
    input  wire logic aclk,
    input  wire logic txd,
    output logic      rxd
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [8:0] got;
    int         cnt = 0;
    initial rxd = 1'b1;
    // data lsb first then parity; caller sets parity
    task automatic send(input logic [8:0] f);
        rxd <= 1'b0;
        repeat (P) @(posedge aclk);
        for (int i = 0; i < 9; i++) begin
            rxd <= f[i];
            repeat (P) @(posedge aclk);
        end
        rxd <= 1'b1;
        repeat (P) @(posedge aclk);
    endtask : send
    initial forever begin
        @(negedge txd);
        repeat (P + P / 2) @(posedge aclk);
        for (int i = 0; i < 9; i++) begin
            got[i] = txd;
            repeat (P) @(posedge aclk);
        end
        cnt++;
    end
endmodule : asp3_peer

// >>> test/test_async_serial_port_three.sv
`include "asp3_regs.svh"
module test_async_serial_port_three;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0, aresetn = 1'b0, txd, irq, rxd;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, ext_baud_pin = 1'b0, first_oscillator = 1'b0, second_oscillator = 1'b0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] s_axi_wstrb = 4'h1;
    int err_total = 0, compares = 0;
    always #5 aclk = ~aclk;
    asp3_top asp3_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .ext_baud_pin, .first_oscillator, .second_oscillator,
        .rxd, .txd, .irq);
    asp3_peer #(.P(8)) asp3_peer_inst (.aclk, .txd, .rxd);
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rd(input logic [15:0] i, input logic [7:0] e, input logic [1:0] r = 2'b00);
        @(posedge aclk);
        s_axi_araddr <= {14'h0, i, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk("rdata", {24'h0, e}, s_axi_rdata);
        chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
    endtask : rd
    task automatic wr(input logic [15:0] i, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= {14'h0, i, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'h0, {30'h0, s_axi_bresp});
    endtask : wr
    task automatic final_report;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (3000) @(posedge aclk);
        err_total++;
        final_report;
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`ASP3_IDX_CTRL, 8'h20);
        rd(`ASP3_IDX_BAUD, 8'h00);
        rd(16'h0, 8'h00, 2'b10);
        $display("test reset done");
        wr(`ASP3_IDX_BAUD, 8'h01);
        wr(`ASP3_IDX_FMT, 8'h0c);
        wr(`ASP3_IDX_CTRL, 8'h48);
        wr(`ASP3_IDX_TXH, 8'ha5);
        wait (asp3_peer_inst.cnt == 1);
        chk("frame", {23'h0, ~^8'ha5, 8'ha5}, {23'h0, asp3_peer_inst.got});
        wait (irq === 1'b1);
        rd(`ASP3_IDX_CTRL, 8'he8);
        wr(`ASP3_IDX_FMT, 8'h84);
        wr(`ASP3_IDX_TXH, 8'h5a);
        rd(`ASP3_IDX_CTRL, 8'h68);
        wait (irq === 1'b1);
        chk("frame", {23'h0, ^8'h5a, 8'h5a}, {23'h0, asp3_peer_inst.got});
        wr(`ASP3_IDX_FMT, 8'h0c);
        wr(`ASP3_IDX_CTRL, 8'h08);
        rd(`ASP3_IDX_CTRL, 8'h28);
        chk("irq", 32'h0, {31'h0, irq});
        $display("test transmit done");
        asp3_peer_inst.send({~^8'h3c, 8'h3c});
        rd(`ASP3_IDX_CTRL, 8'h2a);
        rd(`ASP3_IDX_RXH, 8'h3c);
        rd(`ASP3_IDX_CTRL, 8'h28);
        // second frame lands before the first is read
        asp3_peer_inst.send({~^8'h81, 8'h81});
        asp3_peer_inst.send({~^8'h7e, 8'h7e});
        rd(`ASP3_IDX_CTRL, 8'h2e);
        rd(`ASP3_IDX_RXH, 8'h7e);
        wr(`ASP3_IDX_FMT, 8'h0d);
        rd(`ASP3_IDX_FMT, 8'h0d);
        asp3_peer_inst.send({1'b1, 8'h81});
        rd(`ASP3_IDX_FMT, 8'h0f);
        $display("test receive done");
        final_report;
    end
endmodule : test_async_serial_port_three
